// ### dv/fus_regs_bench.sv
// Self-checking bench for the fetch-unit status, pseudo and context registers
`timescale 1ns/100ps
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin nMismatch++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module fus_regs_bench;
  import fus_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic clkEn = 1'b1;
  logic moveTo = 1'b0, moveFrom = 1'b0, sampleDone = 1'b0, sTrap = 1'b0, sLdSt = 1'b0;
  logic sMiss = 1'b0, parErr = 1'b0, retStall = 1'b0, wakeUp = 1'b0;
  logic [7:0] regIndex = 8'h00;
  logic [63:0] writeData = 64'h0;
  logic [63:0] readData;
  logic [3:0] sKind = 4'h0;
  logic [2:0] sOver = 3'h0;
  fus_mispredict_type sCause = CAUSE_OTHER;
  logic parFlush, replayTrap, corrIrq, fullFlush, ngFlush, mapClear, sleepReq, pllSlow;
  int nMismatch = 0;
  int nCompared = 0;

  fus_regs dut (.clk(clk), .resetn(resetn), .clkEn(clkEn), .moveToProcReg(moveTo),
    .moveFromProcReg(moveFrom), .regIndex(regIndex), .writeData(writeData),
    .readData(readData), .sampleDone(sampleDone), .sampleTrapped(sTrap),
    .sampleCause(sCause), .sampleReplayLdStOrder(sLdSt), .sampleTrapKind(sKind),
    .sampleFetchMiss(sMiss), .sampleOvercount(sOver), .fetchParityError(parErr),
    .icacheParityFlush(parFlush), .replayTrap(replayTrap), .correctableReadIrq(corrIrq),
    .firmwareReturnStall(retStall), .icacheFullFlush(fullFlush),
    .icacheNonglobalFlush(ngFlush), .renameMapClear(mapClear), .sleepRequest(sleepReq),
    .pllSlow(pllSlow), .wakeUp(wakeUp));

  // Clock generation
  always #5 clk = ~clk;

  // Step to just after the next rising edge
  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  // One write on the processor register port
  task automatic wr(input logic [7:0] idx, input logic [63:0] d);
    regIndex = idx;
    writeData = d;
    moveTo = 1'b1;
    tick();
    moveTo = 1'b0;
  endtask

  // One read on the processor register port, compared one edge later
  task automatic rd(input logic [7:0] idx, input logic [63:0] e);
    regIndex = idx;
    moveFrom = 1'b1;
    tick();
    `CHK(readData, e)
    moveFrom = 1'b0;
  endtask

  // Context bits enabled by a field-enable pattern
  function automatic logic [63:0] fmask(input logic [4:0] en);
    logic [63:0] m;
    m = 64'h0;
    if (en[EN_ASN]) m[CTX_ASN_LO +: 8] = 8'hFF;
    if (en[EN_ASYNC_TRAP_ENABLE]) m[CTX_ASYNC_TRAP_ENABLE_LO +: 4] = 4'hF;
    if (en[EN_ASYNC_TRAP_REQUEST]) m[CTX_ASYNC_TRAP_REQUEST_LO +: 4] = 4'hF;
    if (en[EN_PROCESS_COUNT_ENABLE]) m[CTX_PROCESS_COUNT_ENABLE] = 1'b1;
    if (en[EN_FPE]) m[CTX_FPE] = 1'b1;
    return m;
  endfunction

  // Expected status word after one sample report
  function automatic logic [63:0] sexp(input logic t, input logic [1:0] c, input logic l,
      input logic [3:0] k, input logic mi, input logic [2:0] o);
    logic [63:0] s;
    s = 64'h0;
    s[ST_MISPREDICT] = t && (c == 2'h1);
    s[ST_TRAPPED] = t;
    s[ST_LDST_ORDER] = t && l && (k == 4'h0);
    s[ST_KIND_LO +: 4] = (t && !(k inside {4'h1, 4'h9, 4'hB, 4'hD})) ? k : 4'h0;
    s[ST_FETCH_MISS] = mi;
    s[ST_OVER_LO +: 3] = o;
    return s;
  endfunction

  // Report one sample and read the status back
  task automatic samp(input logic t, input logic [1:0] c, input logic l, input logic [3:0] k,
      input logic mi, input logic [2:0] o);
    sTrap = t;
    sCause = fus_mispredict_type'(c);
    sLdSt = l;
    sKind = k;
    sMiss = mi;
    sOver = o;
    sampleDone = 1'b1;
    tick();
    sampleDone = 1'b0;
    rd(IDX_STATUS, sexp(t, c, l, k, mi, o));
  endtask

  task automatic printVerdict();
    $display("Comparisons %0d, mismatches %0d", nCompared, nMismatch);
    if (nMismatch == 0 && nCompared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Watchdog against a hung run
  initial begin
    repeat (5000) @(posedge clk);
    nMismatch++;
    printVerdict();
  end

  // Main sequence
  initial begin : mainSeq
    logic [63:0] ctx, d, m;
    logic [4:0] en;
    logic [7:0] pidx [3];
    int k;
    pidx = '{IDX_NONGLOBAL_FLUSH, IDX_MAP_CLEAR, IDX_SLEEP};
    repeat (4) @(posedge clk);
    #1 resetn = 1'b1;
    rd(IDX_STATUS, 64'h0);
    ctx = 64'h4;
    tick();
    rd(8'h40, ctx);
    // Field-selective context writes against a running model
    for (k = 0; k < 7; k++) begin
      en = (k < 5) ? 5'(1 << k) : ((k == 5) ? 5'h1F : 5'h00);
      d = k[0] ? 64'hFFFF_FFFF_FFFF_FFFF : 64'h5A5A_5A5A_5A5A_5A5A;
      m = fmask(en);
      wr(8'h40 | {3'h0, en}, d);
      ctx = (ctx & ~m) | (d & m);
      rd(8'h40, ctx);
    end
    wr(8'h9F, 64'h0);
    rd(8'h40, ctx);
    clkEn = 1'b0;
    wr(8'h5F, 64'h0);
    clkEn = 1'b1;
    rd(8'h40, ctx);
    wr(IDX_STATUS, 64'hFFFF_FFFF_DFFF_FFFF);
    rd(IDX_STATUS, 64'h0);
    // Every trap kind, with all three mispredict causes in turn
    for (k = 0; k < 16; k++) begin
      samp(1'b1, 2'(k % 3), 1'b1, 4'(k), k[0], 3'(k));
    end
    samp(1'b0, 2'h1, 1'b1, 4'h5, 1'b1, 3'h7);
    samp(1'b1, 2'h0, 1'b0, 4'h0, 1'b0, 3'h0);
    samp(1'b0, 2'h0, 1'b0, 4'h0, 1'b0, 3'h0);
    // Parity error, zero write, set beating clear, then one-clear
    parErr = 1'b1;
    tick();
    parErr = 1'b0;
    `CHK({parFlush, replayTrap, corrIrq}, 3'b111)
    tick();
    `CHK({parFlush, replayTrap, corrIrq}, 3'b000)
    rd(IDX_STATUS, 64'h2000_0000);
    wr(IDX_STATUS, 64'h0);
    rd(IDX_STATUS, 64'h2000_0000);
    parErr = 1'b1;
    wr(IDX_STATUS, 64'h2000_0000);
    parErr = 1'b0;
    rd(IDX_STATUS, 64'h2000_0000);
    wr(IDX_STATUS, 64'h2000_0000);
    rd(IDX_STATUS, 64'h0);
    // Pseudo registers with immediate effect
    // written only with no sample or flush outstanding
    for (k = 0; k < 3; k++) begin
      wr(pidx[k], 64'h0);
      `CHK({ngFlush, mapClear, sleepReq, fullFlush}, 4'h8 >> k)
      tick();
      `CHK({ngFlush, mapClear, sleepReq}, 3'b000)
    end
    `CHK(pllSlow, 1'b1)
    wakeUp = 1'b1;
    tick();
    wakeUp = 1'b0;
    tick();
    `CHK(pllSlow, 1'b0)
    // Full flush waits for the return-with-stall retire
    wr(IDX_FULL_FLUSH, 64'h0);
    `CHK(fullFlush, 1'b0)
    tick();
    `CHK(fullFlush, 1'b0)
    retStall = 1'b1;
    tick();
    retStall = 1'b0;
    `CHK(fullFlush, 1'b1)
    tick();
    `CHK(fullFlush, 1'b0)
    printVerdict();
  end
endmodule

// ### verilog/fus_context.sv
// Process context register with field-selective writes
`timescale 1ns/100ps
module fus_context (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic writeEn,
  input wire logic [4:0] fieldEn,
  input wire logic [63:0] writeData,
  output logic [63:0] readData
);
  import fus_pkg::*;
  logic [7:0] address_space_number;
  logic [3:0] astEnable;
  logic [3:0] astRequest;
  logic countEnable;
  logic floatEnable;

  // Each field loads only when its index bit is set
  // RQ16 RQ17 RQ18 RQ19 field enables
  always_ff @(posedge clk) begin
    if (!resetn) begin
      address_space_number <= ASN_RESET;
      astEnable <= AST_RESET;
      astRequest <= AST_RESET;
      countEnable <= 1'b0;
      floatEnable <= FPE_RESET;
    end else if (clkEn && writeEn) begin
      if (fieldEn[EN_ASN]) address_space_number <= writeData[CTX_ASN_LO +: 8];
      if (fieldEn[EN_ASYNC_TRAP_ENABLE]) astEnable <= writeData[CTX_ASYNC_TRAP_ENABLE_LO +: 4];
      if (fieldEn[EN_ASYNC_TRAP_REQUEST]) astRequest <= writeData[CTX_ASYNC_TRAP_REQUEST_LO +: 4];
      if (fieldEn[EN_PROCESS_COUNT_ENABLE]) countEnable <= writeData[CTX_PROCESS_COUNT_ENABLE];
      if (fieldEn[EN_FPE]) floatEnable <= writeData[CTX_FPE];
    end
  end

  // RQ18 whole read
  assign readData = {17'h00000, address_space_number, 26'h0000000, astRequest, astEnable,
                     2'h0, floatEnable, countEnable, 1'b0};

  property p_fpe_reset;
    @(posedge clk) !resetn |=> readData[CTX_FPE];
  endproperty
  a_fpe_reset: assert property (p_fpe_reset) else $error("float enable not set by reset"); // RQ19
  property p_masked_hold;
    @(posedge clk) disable iff (!resetn)
      (clkEn && writeEn && !fieldEn[EN_ASN]) |=> $stable(readData[CTX_ASN_LO +: 8]);
  endproperty
  a_masked_hold: assert property (p_masked_hold) else $error("unselected field changed"); // RQ16
  property p_asn_load;
    @(posedge clk) disable iff (!resetn)
      (clkEn && writeEn && fieldEn[EN_ASN])
      |=> readData[CTX_ASN_LO +: 8] == $past(writeData[CTX_ASN_LO +: 8]);
  endproperty
  a_asn_load: assert property (p_asn_load) else $error("address space field not loaded"); // RQ17
  property p_fpe_load;
    @(posedge clk) disable iff (!resetn)
      (clkEn && writeEn && fieldEn[EN_FPE]) |=> readData[CTX_FPE] == $past(writeData[CTX_FPE]);
  endproperty
  a_fpe_load: assert property (p_fpe_load) else $error("float enable not loaded"); // RQ18
  c_multi_field: cover property (@(posedge clk) clkEn && writeEn && (&fieldEn));
endmodule

// ### verilog/fus_pkg.sv
// Constants and types shared by the fetch-unit status and pseudo register block
// Behaviour
// RQ1 - Status register readable; parity bit write-one-clears; other fields read-only.
// RQ2 - Bit 40 set for sampled branch mispredict trap, not jump/call/return/coroutine.
// RQ3 - Bit 39 set whenever the sampled instruction trapped.
// RQ4 - Bit 38 set only when a replay trap was a load-store order violation.
// RQ5 - Bits 37:34 encode trap kind; codes 1, 9, 11, 13 invalid.
// RQ6 - Fetch-translation misses, fetch violations and interrupts never reported in trap kind.
// RQ7 - Bit 33 set when sample's fetch block started a new cache fill stream.
// RQ8 - Bits 32:30 hold counter 0 overcount, 0 to 7.
// RQ9 - Fetch parity error sets bit 29, flushes cache, replays, requests interrupt.
// RQ10 - Full-flush write invalidates all blocks when next return-with-stall retires.
// RQ11 - Non-global flush write invalidates blocks whose global-match bit is clear.
// RQ12 - Map-clear write clears the rename map.
// RQ13 - Software writes map-clear only with no dependencies and nothing unretired.
// RQ14 - Sleep write lowers PLL speed and enters low-power mode.
// RQ15 - Software saves state, flushes caches and unmasks wake interrupts before sleep.
// RQ16 - Index bits 7:6 equal 01 select context; bits 4:0 are field write enables.
// RQ17 - Index bits 0..3 enable address space, trap enable, trap request, counting enable.
// RQ18 - Index bit 4 enables float enable; context read returns all fields.
// RQ19 - Float enable at context bit 2 is set on reset.
// RQ20 - Zero writes to parity bit and writes to read-only fields have no effect.
// RQ21 - Sample fields update together when a sample completes.
package fus_pkg;
  // Register indices on the processor register port (context uses its own decode)
  localparam logic [7:0] IDX_STATUS = 8'h16;
  localparam logic [7:0] IDX_FULL_FLUSH = 8'h13;
  localparam logic [7:0] IDX_NONGLOBAL_FLUSH = 8'h12;
  localparam logic [7:0] IDX_MAP_CLEAR = 8'h15;
  localparam logic [7:0] IDX_SLEEP = 8'h17;
  localparam logic [1:0] CTX_SELECT = 2'h1;
  // Status register field positions
  localparam int ST_MISPREDICT = 40;
  localparam int ST_TRAPPED = 39;
  localparam int ST_LDST_ORDER = 38;
  localparam int ST_KIND_LO = 34;
  localparam int ST_FETCH_MISS = 33;
  localparam int ST_OVER_LO = 30;
  localparam int ST_PARITY = 29;
  // Context register field positions
  localparam int CTX_ASN_LO = 39;
  localparam int CTX_ASYNC_TRAP_REQUEST_LO = 9;
  localparam int CTX_ASYNC_TRAP_ENABLE_LO = 5;
  localparam int CTX_FPE = 2;
  localparam int CTX_PROCESS_COUNT_ENABLE = 1;
  // Index bit enabling each context field
  localparam int EN_ASN = 0;
  localparam int EN_ASYNC_TRAP_ENABLE = 1;
  localparam int EN_ASYNC_TRAP_REQUEST = 2;
  localparam int EN_PROCESS_COUNT_ENABLE = 3;
  localparam int EN_FPE = 4;
  // Reset values
  localparam logic FPE_RESET = 1'b1;
  localparam logic [7:0] ASN_RESET = 8'h00;
  localparam logic [3:0] AST_RESET = 4'h0;
  // Sampled-trap report payload from the pipeline
  typedef enum logic [1:0] {
    CAUSE_OTHER,
    CAUSE_BRANCH,
    CAUSE_JUMP
  } fus_mispredict_type;
  typedef enum logic [3:0] {
    TK_REPLAY = 4'h0,
    TK_DOUBLE3 = 4'h2,
    TK_DOUBLE4 = 4'h3,
    TK_FP_OFF = 4'h4,
    TK_UNALIGNED = 4'h5,
    TK_SINGLE = 4'h6,
    TK_DFAULT = 4'h7,
    TK_ILLEGAL = 4'h8,
    TK_MCHECK = 4'hA,
    TK_ARITH = 4'hC,
    TK_FPCR = 4'hE,
    TK_RESET = 4'hF
  } fus_trap_kind_type;
  // Sequencing states for a pending full flush
  typedef enum logic {
    FL_IDLE,
    FL_ARMED
  } fus_flush_state_type;
endpackage

// ### verilog/fus_regs.sv
// Fetch-unit status register, pseudo registers and context write decode
`timescale 1ns/100ps
module fus_regs (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clkEn,
  // Move-to / move-from processor register port
  input wire logic moveToProcReg,
  input wire logic moveFromProcReg,
  input wire logic [7:0] regIndex,
  input wire logic [63:0] writeData,
  output logic [63:0] readData,
  // Sample completion report
  input wire logic sampleDone,
  input wire logic sampleTrapped,
  input wire fus_pkg::fus_mispredict_type sampleCause,
  input wire logic sampleReplayLdStOrder,
  input wire logic [3:0] sampleTrapKind,
  input wire logic sampleFetchMiss,
  input wire logic [2:0] sampleOvercount,
  // Fetch parity detection and its consequences
  input wire logic fetchParityError,
  output logic icacheParityFlush,
  output logic replayTrap,
  output logic correctableReadIrq,
  // Pseudo register effects
  input wire logic firmwareReturnStall,
  output logic icacheFullFlush,
  output logic icacheNonglobalFlush,
  output logic renameMapClear,
  output logic sleepRequest,
  output logic pllSlow,
  input wire logic wakeUp
);
  import fus_pkg::*;

  logic mispredict;
  logic trapped;
  logic ldStOrder;
  logic [3:0] trapKind;
  logic fetchMiss;
  logic [2:0] overcount;
  logic parity;
  fus_flush_state_type flushState;
  logic lowPower;

  // Register decode
  wire ctxHit = regIndex[7:6] == CTX_SELECT;
  wire statusHit = regIndex == IDX_STATUS;
  wire wrStatus = moveToProcReg && statusHit;
  wire wrFull = moveToProcReg && regIndex == IDX_FULL_FLUSH;
  wire wrNonglobal = moveToProcReg && regIndex == IDX_NONGLOBAL_FLUSH;
  wire wrMapClear = moveToProcReg && regIndex == IDX_MAP_CLEAR;
  wire wrSleep = moveToProcReg && regIndex == IDX_SLEEP;
  wire [63:0] ctxData;

  // Trap kind is only meaningful for valid codes; invalid codes collapse to replay
  function automatic logic [3:0] legalKind(input logic [3:0] k);
    unique case (k)
      4'h1, 4'h9, 4'hB, 4'hD: legalKind = TK_REPLAY;
      default: legalKind = k;
    endcase
  endfunction

  // Derived sample fields, qualified by the trap bit
  // RQ2 branch only
  wire next_mispredict = sampleTrapped && sampleCause == CAUSE_BRANCH;
  // RQ4 order violation only for replay traps
  wire next_ldStOrder = sampleTrapped && sampleTrapKind == TK_REPLAY && sampleReplayLdStOrder;
  // RQ5 RQ6 pipeline-redirect traps arrive untrapped so kind stays clear
  wire [3:0] next_trapKind = sampleTrapped ? legalKind(sampleTrapKind) : 4'h0;
  // RQ1 RQ9 RQ20 set beats a one-write clear, zero writes ignored
  wire next_parity = fetchParityError || (parity && !(wrStatus && writeData[ST_PARITY]));

  // RQ21 sample fields captured together
  // RQ3 RQ7 RQ8 trap, fill and overcount fields
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mispredict <= 1'b0;
      trapped <= 1'b0;
      ldStOrder <= 1'b0;
      trapKind <= 4'h0;
      fetchMiss <= 1'b0;
      overcount <= 3'h0;
    end else if (clkEn && sampleDone) begin
      mispredict <= next_mispredict;
      trapped <= sampleTrapped;
      ldStOrder <= next_ldStOrder;
      trapKind <= next_trapKind;
      fetchMiss <= sampleFetchMiss;
      overcount <= sampleOvercount;
    end
  end

  // Parity flag
  always_ff @(posedge clk) begin
    if (!resetn) parity <= 1'b0;
    else if (clkEn) parity <= next_parity;
  end

  // RQ9 parity consequences as one-cycle pulses
  always_ff @(posedge clk) begin
    if (!resetn) begin
      icacheParityFlush <= 1'b0;
      replayTrap <= 1'b0;
      correctableReadIrq <= 1'b0;
    end else if (clkEn) begin
      icacheParityFlush <= fetchParityError;
      replayTrap <= fetchParityError;
      correctableReadIrq <= fetchParityError;
    end
  end

  // RQ10 full flush waits for a return-with-stall retire
  always_ff @(posedge clk) begin
    if (!resetn) begin
      flushState <= FL_IDLE;
      icacheFullFlush <= 1'b0;
    end else if (clkEn) begin
      icacheFullFlush <= 1'b0;
      unique case (flushState)
        FL_IDLE: if (wrFull) flushState <= FL_ARMED;
        FL_ARMED: if (firmwareReturnStall) begin
          icacheFullFlush <= 1'b1;
          flushState <= FL_IDLE;
        end
      endcase
    end
  end

  // RQ11 RQ12 RQ14 immediate pseudo register strobes and sleep state
  always_ff @(posedge clk) begin
    if (!resetn) begin
      icacheNonglobalFlush <= 1'b0;
      renameMapClear <= 1'b0;
      sleepRequest <= 1'b0;
      lowPower <= 1'b0;
    end else if (clkEn) begin
      icacheNonglobalFlush <= wrNonglobal;
      renameMapClear <= wrMapClear;
      sleepRequest <= wrSleep;
      if (wrSleep) lowPower <= 1'b1;
      else if (wakeUp) lowPower <= 1'b0;
    end
  end
  assign pllSlow = lowPower;

  // RQ16 context decode
  fus_context uContext (
    .clk(clk),
    .resetn(resetn),
    .clkEn(clkEn),
    .writeEn(moveToProcReg && ctxHit),
    .fieldEn(regIndex[4:0]),
    .writeData(writeData),
    .readData(ctxData)
  );

  // RQ1 RQ20 read mux, reserved bits zero
  wire [63:0] statusWord = {23'h000000, mispredict, trapped, ldStOrder, trapKind,
                            fetchMiss, overcount, parity, 29'h00000000};
  assign readData = !moveFromProcReg ? 64'h0 : statusHit ? statusWord
                  : ctxHit ? ctxData : 64'h0;

  property p_parity_set;
    @(posedge clk) disable iff (!resetn) (clkEn && fetchParityError) |=> parity;
  endproperty
  a_parity_set: assert property (p_parity_set) else $error("parity flag not set"); // RQ9
  property p_parity_zero_write;
    @(posedge clk) disable iff (!resetn)
      (clkEn && parity && !(wrStatus && writeData[ST_PARITY])) |=> parity;
  endproperty
  a_parity_zero_write: assert property (p_parity_zero_write) else $error("parity lost"); // RQ20
  property p_parity_clear;
    @(posedge clk) disable iff (!resetn)
      (clkEn && wrStatus && writeData[ST_PARITY] && !fetchParityError) |=> !parity;
  endproperty
  a_parity_clear: assert property (p_parity_clear) else $error("parity not cleared"); // RQ1
  property p_mis_branch;
    @(posedge clk) disable iff (!resetn)
      (clkEn && sampleDone && sampleCause == CAUSE_JUMP) |=> !mispredict;
  endproperty
  a_mis_branch: assert property (p_mis_branch) else $error("jump set mispredict"); // RQ2
  property p_trap_qualifies;
    @(posedge clk) disable iff (!resetn) (mispredict || ldStOrder) |-> trapped;
  endproperty
  a_trap_qualifies: assert property (p_trap_qualifies) else $error("unqualified field"); // RQ3
  property p_kind_valid;
    @(posedge clk) disable iff (!resetn)
      !(trapKind inside {4'h1, 4'h9, 4'hB, 4'hD});
  endproperty
  a_kind_valid: assert property (p_kind_valid) else $error("invalid trap kind"); // RQ5
  property p_flush_waits;
    @(posedge clk) disable iff (!resetn)
      (clkEn && wrFull && !firmwareReturnStall) |=> !icacheFullFlush;
  endproperty
  a_flush_waits: assert property (p_flush_waits) else $error("flush before stall retire"); // RQ10
  property p_map_clear;
    @(posedge clk) disable iff (!resetn) (clkEn && wrMapClear) |=> renameMapClear;
  endproperty
  a_map_clear: assert property (p_map_clear) else $error("map clear missed"); // RQ12
  property p_sleep;
    @(posedge clk) disable iff (!resetn) (clkEn && wrSleep) |=> (pllSlow && sleepRequest);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not entered"); // RQ14
  property p_overcount;
    @(posedge clk) disable iff (!resetn)
      (clkEn && sampleDone) |=> overcount == $past(sampleOvercount);
  endproperty
  a_overcount: assert property (p_overcount) else $error("overcount not captured"); // RQ8
  property p_parity_pulses;
    @(posedge clk) disable iff (!resetn)
      (clkEn && fetchParityError) |=> (icacheParityFlush && replayTrap && correctableReadIrq);
  endproperty
  a_parity_pulses: assert property (p_parity_pulses) else $error("parity pulses missed"); // RQ9
  property p_ldst_replay;
    @(posedge clk) disable iff (!resetn) ldStOrder |-> trapKind == TK_REPLAY;
  endproperty
  a_ldst_replay: assert property (p_ldst_replay) else $error("order bit off replay"); // RQ4
  property p_untrapped_kind;
    @(posedge clk) disable iff (!resetn) !trapped |-> trapKind == 4'h0;
  endproperty
  a_untrapped_kind: assert property (p_untrapped_kind) else $error("kind without trap"); // RQ6
  property p_flush_fires;
    @(posedge clk) disable iff (!resetn)
      (clkEn && flushState == FL_ARMED && firmwareReturnStall) |=> icacheFullFlush;
  endproperty
  a_flush_fires: assert property (p_flush_fires) else $error("armed flush not issued"); // RQ10
  property p_nonglobal;
    @(posedge clk) disable iff (!resetn) (clkEn && wrNonglobal) |=> icacheNonglobalFlush;
  endproperty
  a_nonglobal: assert property (p_nonglobal) else $error("non-global flush missed"); // RQ11
  c_parity: cover property (@(posedge clk) fetchParityError && clkEn);
  c_flush: cover property (@(posedge clk) icacheFullFlush);
  c_trap: cover property (@(posedge clk) trapped && ldStOrder);
endmodule
